// file: peoc_defs.vh
// Register map, field positions and reset values of the pulse emulation chain
`ifndef PEOC_DEFS_VH
`define PEOC_DEFS_VH

// Register byte offsets
`define PEOC_OFF_CTRL      8'h00
`define PEOC_OFF_FIXED     8'h04
`define PEOC_OFF_RATE      8'h08
`define PEOC_OFF_SHAPE     8'h0C
`define PEOC_OFF_OFFSET    8'h10
`define PEOC_OFF_GAIN      8'h14
`define PEOC_OFF_SPADDR    8'h18
`define PEOC_OFF_SPDATA    8'h1C
`define PEOC_OFF_SEQ       8'h20
`define PEOC_OFF_AWG       8'h24
`define PEOC_OFF_COUNT     8'h28
`define PEOC_OFF_OUT       8'h2C
`define PEOC_OFF_STAT      8'h30

// Control register fields
`define PEOC_CTRL_EN       0
`define PEOC_CTRL_INV      1
`define PEOC_CTRL_AWG      2
`define PEOC_CTRL_EM_LO    3
`define PEOC_CTRL_EM_HI    4
`define PEOC_CTRL_POIS     5
`define PEOC_CTRL_DM_LO    6
`define PEOC_CTRL_DM_HI    7
`define PEOC_CTRL_DS_LO    8
`define PEOC_CTRL_DS_HI    11
`define PEOC_CTRL_SL_LO    12
`define PEOC_CTRL_SL_HI    15

// Energy modes and decimation modes
`define PEOC_EM_FIXED      2'h0
`define PEOC_EM_SPEC       2'h1
`define PEOC_EM_SEQ        2'h2
`define PEOC_DM_FIRST      2'h0
`define PEOC_DM_MAX        2'h1
`define PEOC_DM_SLICE      2'h2

// Shape register fields: shift exponents of rise and decay filters
`define PEOC_SHP_RISE_LO   0
`define PEOC_SHP_RISE_HI   3
`define PEOC_SHP_DEC_LO    4
`define PEOC_SHP_DEC_HI    7

// Gain is unsigned Q2.14: 16'h4000 is 1.0, 16'h8000 is 2.0
`define PEOC_GAIN_FRAC     14
`define PEOC_GAIN_MAX      16'h8000

// Reset values
`define PEOC_RST_CTRL      16'h0000
`define PEOC_RST_FIXED     16'h1000
`define PEOC_RST_RATE      32'h0000_0000
`define PEOC_RST_SHAPE     8'h80
`define PEOC_RST_OFFSET    16'h0000
`define PEOC_RST_GAIN      16'h4000

`endif

// file: peoc_lfsr.v
// Free running 32-bit Galois LFSR used as pseudo-random source
`timescale 1ns/1ps
`default_nettype none
module peoc_lfsr #(
    parameter [31:0] SEED = 32'h1234_5678
) (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_n_i,
    // Random word, new value every cycle
    output wire [31:0] rnd_o
);
    reg [31:0] state_q;

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= SEED;
        end else if (state_q[0]) begin
            // Maximal length taps, the all-zero state is never reached
            state_q <= {1'b0, state_q[31:1]} ^ 32'h8020_0003;
        end else begin
            state_q <= {1'b0, state_q[31:1]};
        end
    end

    assign rnd_o = state_q;
endmodule
`default_nettype wire

// file: peoc_shaper.v
// Digital RC pulse shaper: exponential decay followed by exponential rise
`timescale 1ns/1ps
`default_nettype none
module peoc_shaper (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_n_i,
    // Pulse trigger and amplitude
    input  wire        fire_i,
    input  wire [15:0] amp_i,
    // Filter shift exponents
    input  wire [3:0]  rise_sh_i,
    input  wire [3:0]  decay_sh_i,
    // Shaped sample
    output wire [15:0] y_o
);
    reg  [19:0] dec_q;
    reg  [19:0] rise_q;
    wire [3:0]  dsh = (decay_sh_i == 4'h0) ? 4'h1 : decay_sh_i;
    wire [19:0] dec_loss = dec_q >> dsh;
    wire [20:0] dec_add = {1'b0, dec_q - dec_loss} + {1'b0, amp_i, 4'h0};
    wire signed [20:0] diff = $signed({1'b0, dec_q}) - $signed({1'b0, rise_q});
    wire signed [20:0] step = diff >>> rise_sh_i;

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dec_q  <= 20'h00000;
            rise_q <= 20'h00000;
        end else begin
            // Piled-up pulses saturate instead of wrapping
            if (fire_i) begin
                dec_q <= dec_add[20] ? 20'hFFFFF : dec_add[19:0];
            end else begin
                dec_q <= dec_q - dec_loss;
            end
            if (rise_sh_i == 4'h0) begin
                rise_q <= dec_q;
            end else begin
                rise_q <= rise_q + step[19:0];
            end
        end
    end

    assign y_o = rise_q[19:4];
endmodule
`default_nettype wire

// file: peoc_top.v
// Pulse emulation and output conditioning chain with APB register access
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
`include "peoc_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module peoc_top #(
    parameter DEPTH   = 16384,
    parameter SEQ_LEN = 16
) (
    // Clock and reset
    input  wire        CORE_CLK_I,
    input  wire        RST_N_I,
    // APB slave
    input  wire        PSEL_I,
    input  wire        PENABLE_I,
    input  wire        PWRITE_I,
    input  wire [7:0]  PADDR_I,
    input  wire [31:0] PWDATA_I,
    output reg  [31:0] PRDATA_O,
    output wire        PREADY_O,
    output reg         PSLVERR_O,
    // Converter side
    output wire [15:0] DAC_DATA_O,
    output wire        PULSE_O
);
    localparam AW     = $clog2(DEPTH);
    localparam SW     = $clog2(SEQ_LEN);
    localparam AMP_SH = 16 - AW;
    localparam [3:0] ST_PICK = 4'b0001;
    localparam [3:0] ST_SCAN = 4'b0010;
    localparam [3:0] ST_TEST = 4'b0100;
    localparam [3:0] ST_RDY  = 4'b1000;

    // Registers
    reg [15:0]   ctrl_q;
    reg [15:0]   fixed_q;
    reg [31:0]   rate_q;
    reg [7:0]    shape_q;
    reg [15:0]   offset_q;
    reg [15:0]   gain_q;
    reg [AW-1:0] spaddr_q;
    reg [15:0]   awg_q;
    reg [31:0]   count_q;
    reg [15:0]   spec_mem [0:DEPTH-1];
    reg [15:0]   seq_mem [0:SEQ_LEN-1];
    reg [SW-1:0] seq_idx_q;

    // Sampler state
    reg [3:0]    st_q;
    reg [AW-1:0] win_q;
    reg [AW-1:0] rd_idx_q;
    reg [AW:0]   cnt_q;
    reg [15:0]   max_q;
    reg [15:0]   amp_next_q;

    // Timing and output pipeline
    reg [31:0]   acc_q;
    reg [15:0]   sum_q;
    reg [15:0]   out_q;
    reg          pulse_q;

    wire        ch_en    = ctrl_q[`PEOC_CTRL_EN];
    wire        invert   = ctrl_q[`PEOC_CTRL_INV];
    wire        awg_mode = ctrl_q[`PEOC_CTRL_AWG];
    wire [1:0]  e_mode   = ctrl_q[`PEOC_CTRL_EM_HI:`PEOC_CTRL_EM_LO];
    wire        poisson  = ctrl_q[`PEOC_CTRL_POIS];
    wire [1:0]  d_mode   = ctrl_q[`PEOC_CTRL_DM_HI:`PEOC_CTRL_DM_LO];
    wire [3:0]  ds_raw   = ctrl_q[`PEOC_CTRL_DS_HI:`PEOC_CTRL_DS_LO];
    wire [SW-1:0] seq_last = ctrl_q[`PEOC_CTRL_SL_LO+SW-1:`PEOC_CTRL_SL_LO];

    // APB decode: zero-wait slave, every access completes in its first
    // access cycle
    wire        apb_acc  = PSEL_I && PENABLE_I;
    reg         addr_ok;
    wire        apb_wr   = apb_acc && PWRITE_I && addr_ok;
    assign PREADY_O = 1'b1;

    always @* begin
        case (PADDR_I)
            `PEOC_OFF_CTRL, `PEOC_OFF_FIXED, `PEOC_OFF_RATE,
            `PEOC_OFF_SHAPE, `PEOC_OFF_OFFSET, `PEOC_OFF_GAIN,
            `PEOC_OFF_SPADDR, `PEOC_OFF_SPDATA, `PEOC_OFF_SEQ,
            `PEOC_OFF_AWG, `PEOC_OFF_COUNT, `PEOC_OFF_OUT,
            `PEOC_OFF_STAT: addr_ok = 1'b1;
            default:        addr_ok = 1'b0;
        endcase
    end

    // Random sources: one for timing, one for amplitude sampling
    wire [31:0] rnd_t;
    wire [31:0] rnd_a;

    peoc_lfsr #(
        .SEED (32'hACE1_0001)
    ) u_rnd_time (
        .clk_i   (CORE_CLK_I),
        .rst_n_i (RST_N_I),
        .rnd_o   (rnd_t)
    );

    peoc_lfsr #(
        .SEED (32'h5EED_7F03)
    ) u_rnd_amp (
        .clk_i   (CORE_CLK_I),
        .rst_n_i (RST_N_I),
        .rnd_o   (rnd_a)
    );

    // Decimation window: 2**dshift reference bins per target bin
    wire [4:0]    dshift  = ({1'b0, ds_raw} > AW) ? AW[4:0] : {1'b0, ds_raw};
    wire [AW:0]   win_len = {{AW{1'b0}}, 1'b1} << dshift;
    wire [AW-1:0] pick    = rnd_a[AW-1:0] >> dshift;
    wire [15:0]   rd_val  = spec_mem[rd_idx_q];
    wire [15:0]   cand    = (d_mode == `PEOC_DM_MAX) ? max_q : rd_val;
    wire [31:0]   amp_wide = {{(32-AW){1'b0}}, win_q} << (dshift + AMP_SH);

    // Pulse timing
    wire [32:0] acc_sum   = {1'b0, acc_q} + {1'b0, rate_q};
    wire        t_const   = acc_sum[32];
    wire        t_pois    = (rnd_t < rate_q);
    wire        t_fire    = poisson ? t_pois : t_const;
    wire        spec_sel  = (e_mode == `PEOC_EM_SPEC);
    wire        amp_ok    = !spec_sel || (st_q == ST_RDY);
    wire        fire      = ch_en && !awg_mode && t_fire && amp_ok;

    // amplitude source selected by energy mode
    reg [15:0] amp_sel;
    always @* begin
        case (e_mode)
            `PEOC_EM_SPEC: amp_sel = amp_next_q;
            `PEOC_EM_SEQ:  amp_sel = seq_mem[seq_idx_q];
            default:       amp_sel = fixed_q;
        endcase
    end

    wire [15:0] shp_y;
    peoc_shaper u_shaper (
        .clk_i      (CORE_CLK_I),
        .rst_n_i    (RST_N_I),
        .fire_i     (fire),
        .amp_i      (amp_sel),
        .rise_sh_i  (shape_q[`PEOC_SHP_RISE_HI:`PEOC_SHP_RISE_LO]),
        .decay_sh_i (shape_q[`PEOC_SHP_DEC_HI:`PEOC_SHP_DEC_LO]),
        .y_o        (shp_y)
    );

    // Register writes and spectrum address stepping
    always @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ctrl_q   <= `PEOC_RST_CTRL;
            fixed_q  <= `PEOC_RST_FIXED;
            rate_q   <= `PEOC_RST_RATE;
            shape_q  <= `PEOC_RST_SHAPE;
            offset_q <= `PEOC_RST_OFFSET;
            gain_q   <= `PEOC_RST_GAIN;
            spaddr_q <= {AW{1'b0}};
            awg_q    <= 16'h0000;
        end else if (apb_wr) begin
            case (PADDR_I)
                `PEOC_OFF_CTRL:   ctrl_q   <= PWDATA_I[15:0];
                `PEOC_OFF_FIXED:  fixed_q  <= PWDATA_I[15:0];
                `PEOC_OFF_RATE:   rate_q   <= PWDATA_I;
                `PEOC_OFF_SHAPE:  shape_q  <= PWDATA_I[7:0];
                `PEOC_OFF_OFFSET: offset_q <= PWDATA_I[15:0];
                `PEOC_OFF_GAIN:   gain_q   <= (PWDATA_I[15:0] >
                                              `PEOC_GAIN_MAX) ?
                                              `PEOC_GAIN_MAX :
                                              PWDATA_I[15:0];
                `PEOC_OFF_SPADDR: spaddr_q <= PWDATA_I[AW-1:0];
                // Address steps on so a spectrum streams in word by word
                `PEOC_OFF_SPDATA: spaddr_q <= spaddr_q + 1'b1;
                `PEOC_OFF_AWG:    awg_q    <= PWDATA_I[15:0];
                default: ;
            endcase
        end
    end

    // bins are 16 bits, DEPTH entries
    // loading only fills memory, mode unchanged
    always @(posedge CORE_CLK_I) begin
        if (apb_wr && PADDR_I == `PEOC_OFF_SPDATA) begin
            spec_mem[spaddr_q] <= PWDATA_I[15:0];
        end
        if (apb_wr && PADDR_I == `PEOC_OFF_SEQ) begin
            seq_mem[PWDATA_I[16+SW-1:16]] <= PWDATA_I[15:0];
        end
    end

    // rejection sampler, keeps one amplitude ready ahead of the pulse
    always @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            st_q       <= ST_PICK;
            win_q      <= {AW{1'b0}};
            rd_idx_q   <= {AW{1'b0}};
            cnt_q      <= {(AW+1){1'b0}};
            max_q      <= 16'h0000;
            amp_next_q <= 16'h0000;
        end else if (apb_wr && PADDR_I == `PEOC_OFF_CTRL) begin
            // A new mode must not reuse an amplitude drawn under the old one
            st_q <= ST_PICK;
        end else begin
            case (st_q)
                ST_PICK: begin
                    win_q <= pick;
                    cnt_q <= {(AW+1){1'b0}};
                    max_q <= 16'h0000;
                    if (d_mode == `PEOC_DM_SLICE) begin
                        rd_idx_q <= pick;
                        st_q     <= ST_TEST;
                    end else if (d_mode == `PEOC_DM_MAX) begin
                        rd_idx_q <= pick << dshift;
                        st_q     <= ST_SCAN;
                    end else begin
                        rd_idx_q <= pick << dshift;
                        st_q     <= ST_TEST;
                    end
                end
                ST_SCAN: begin
                    if (rd_val > max_q) begin
                        max_q <= rd_val;
                    end
                    rd_idx_q <= rd_idx_q + 1'b1;
                    cnt_q    <= cnt_q + 1'b1;
                    if (cnt_q == win_len - 1'b1) begin
                        st_q <= ST_TEST;
                    end
                end
                ST_TEST: begin
                    // Accept with probability bin height / 65536
                    if (cand > rnd_a[31:16]) begin
                        amp_next_q <= amp_wide[15:0];
                        st_q       <= ST_RDY;
                    end else begin
                        st_q <= ST_PICK;
                    end
                end
                ST_RDY: begin
                    if (fire && spec_sel) begin
                        st_q <= ST_PICK;
                    end
                end
                default: st_q <= ST_PICK;
            endcase
        end
    end

    // Timing accumulator, pulse counter and sequence stepping
    always @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            acc_q     <= 32'h0000_0000;
            count_q   <= 32'h0000_0000;
            seq_idx_q <= {SW{1'b0}};
            pulse_q   <= 1'b0;
        end else begin
            acc_q   <= acc_sum[31:0];
            pulse_q <= fire;
            if (apb_wr && PADDR_I == `PEOC_OFF_COUNT) begin
                count_q <= 32'h0000_0000;
            end else if (fire) begin
                count_q <= count_q + 1'b1;
            end
            if (fire && e_mode == `PEOC_EM_SEQ) begin
                seq_idx_q <= (seq_idx_q >= seq_last) ? {SW{1'b0}} :
                             seq_idx_q + 1'b1;
            end
        end
    end

    // Output chain: select, invert, offset, gain
    wire signed [15:0] pulse_s = $signed({1'b0, shp_y[15:1]});
    wire signed [15:0] src     = awg_mode ? $signed(awg_q) : pulse_s;
    // polarity reversal, one extra bit keeps -(-32768) exact
    wire signed [16:0] inv_s   = invert ? -{src[15], src} : {src[15], src};
    wire signed [17:0] off_s   = {inv_s[16], inv_s} +
                                 {{2{offset_q[15]}}, offset_q};
    wire signed [16:0] gain_s  = $signed({1'b0, gain_q});
    wire signed [32:0] prod    = $signed(sum_q) * gain_s;
    wire signed [32:0] scaled  = prod >>> `PEOC_GAIN_FRAC;

    always @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            sum_q <= 16'h0000;
            out_q <= 16'h0000;
        end else begin
            if (off_s > 18'sd32767) begin
                sum_q <= 16'h7FFF;
            end else if (off_s < -18'sd32768) begin
                sum_q <= 16'h8000;
            end else begin
                sum_q <= off_s[15:0];
            end
            if (!ch_en) begin
                out_q <= 16'h0000;
            end else if (scaled > 33'sd32767) begin
                out_q <= 16'h7FFF;
            end else if (scaled < -33'sd32768) begin
                out_q <= 16'h8000;
            end else begin
                out_q <= scaled[15:0];
            end
        end
    end

    assign DAC_DATA_O = out_q;
    assign PULSE_O    = pulse_q;

    // APB read mux
    always @* begin
        PRDATA_O  = 32'h0000_0000;
        PSLVERR_O = apb_acc && !addr_ok;
        case (PADDR_I)
            `PEOC_OFF_CTRL:   PRDATA_O = {16'h0000, ctrl_q};
            `PEOC_OFF_FIXED:  PRDATA_O = {16'h0000, fixed_q};
            `PEOC_OFF_RATE:   PRDATA_O = rate_q;
            `PEOC_OFF_SHAPE:  PRDATA_O = {24'h00_0000, shape_q};
            `PEOC_OFF_OFFSET: PRDATA_O = {16'h0000, offset_q};
            `PEOC_OFF_GAIN:   PRDATA_O = {16'h0000, gain_q};
            `PEOC_OFF_SPADDR: PRDATA_O = {{(32-AW){1'b0}}, spaddr_q};
            `PEOC_OFF_SPDATA: PRDATA_O = {16'h0000, spec_mem[spaddr_q]};
            `PEOC_OFF_AWG:    PRDATA_O = {16'h0000, awg_q};
            `PEOC_OFF_COUNT:  PRDATA_O = count_q;
            `PEOC_OFF_OUT:    PRDATA_O = {16'h0000, out_q};
            `PEOC_OFF_STAT:   PRDATA_O = {12'h000, st_q, amp_next_q};
            default:          PRDATA_O = 32'h0000_0000;
        endcase
    end
endmodule
`default_nettype wire

// file: peoc_sva.sv
// Port checker for the pulse emulation chain
`timescale 1ns/1ps
`default_nettype none
module peoc_sva (
    // Clock and reset
    input wire logic        CORE_CLK_I,
    input wire logic        RST_N_I,
    // Register bus
    input wire logic        PSEL_I,
    input wire logic        PENABLE_I,
    input wire logic        PWRITE_I,
    input wire logic [7:0]  PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic        PREADY_O,
    input wire logic        PSLVERR_O,
    // Converter side
    input wire logic [15:0] DAC_DATA_O,
    input wire logic        PULSE_O
);
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!RST_N_I);
    logic acc;
    logic wr;
    logic en_q;
    logic gain0_q;
    logic rate0_q;
    assign acc = PSEL_I && PENABLE_I;
    assign wr = acc && PWRITE_I && PREADY_O;
    // Shadow of the settings, updated at the edge a write lands
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            en_q <= 1'b0;
            gain0_q <= 1'b0;
            rate0_q <= 1'b1;
        end else if (wr) begin
            if (PADDR_I == 8'h00)
                en_q <= PWDATA_I[0];
            if (PADDR_I == 8'h14)
                gain0_q <= (PWDATA_I[15:0] == 16'h0);
            if (PADDR_I == 8'h08)
                rate0_q <= (PWDATA_I == 32'h0);
        end
    end
    // Output register needs one edge to see a new setting
    sequence off_s;
        !en_q [*2];
    endsequence
    sequence gain0_s;
        gain0_q [*2];
    endsequence
    // Timing path may hold one event in flight
    sequence idle_s;
        rate0_q [*5];
    endsequence
    ready_high_a: assert property (PREADY_O)
        else $error("pready not high");
    err_access_a: assert property (PSLVERR_O |-> acc)
        else $error("error flag outside access");
    bad_addr_a: assert property (acc && PADDR_I > 8'h30
        |-> PSLVERR_O && PRDATA_O == 32'h0)
        else $error("unmapped access not refused");
    good_addr_a: assert property (acc && PADDR_I <= 8'h30
        && PADDR_I[1:0] == 2'h0 |-> !PSLVERR_O)
        else $error("mapped access refused");
    off_zero_a: assert property (off_s |-> DAC_DATA_O == 16'h0)
        else $error("disabled output not zero");
    off_quiet_a: assert property (off_s |-> !PULSE_O)
        else $error("pulse while disabled");
    gain_zero_a: assert property (gain0_s |-> DAC_DATA_O == 16'h0)
        else $error("zero gain output not zero");
    rate_quiet_a: assert property (idle_s |-> !PULSE_O)
        else $error("pulse at zero rate");
endmodule
bind peoc_top peoc_sva u_peoc_sva (.CORE_CLK_I, .RST_N_I, .PSEL_I,
    .PENABLE_I, .PWRITE_I, .PADDR_I, .PWDATA_I, .PRDATA_O, .PREADY_O,
    .PSLVERR_O, .DAC_DATA_O, .PULSE_O);
`default_nettype wire

// file: peoc_digitizer.sv
// Downstream digitizer model: counts pulses, keeps the highest sample
`timescale 1ns/1ps
`default_nettype none
module peoc_digitizer (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // Converter side
    input  wire logic        clr_i,
    input  wire logic        pulse_i,
    input  wire logic [15:0] sample_i,
    // Measurements
    output var  logic [31:0] hits_o,
    output var  logic [15:0] peak_o
);
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hits_o <= 32'h0;
            peak_o <= 16'h0;
        end else if (clr_i) begin
            hits_o <= 32'h0;
            peak_o <= 16'h0;
        end else begin
            if (pulse_i)
                hits_o <= hits_o + 32'h1;
            // Signed: an inverted swing must not read as a peak
            if ($signed(sample_i) > $signed(peak_o))
                peak_o <= sample_i;
        end
    end
endmodule
`default_nettype wire

// file: peoc_top_tb.sv
// Self-checking bench for the pulse emulation chain
`include "peoc_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module peoc_top_tb;
    localparam logic [31:0] FAST = 32'h2000_0000;
    localparam logic [31:0] SLOW = 32'h0100_0000;
    logic        clk;
    logic        rst_n;
    logic        psel;
    logic        pen;
    logic        pwr;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [15:0] dac;
    logic        pulse;
    logic        clr;
    logic [31:0] hits;
    logic [15:0] peak;
    logic [31:0] rd_q;
    logic        err_q;
    logic [31:0] q;
    logic        e;
    int          errors;
    int          samples_checked;
    int          cyc;
    logic [31:0] rv [6] = '{32'h0, 32'h1000, 32'h0, 32'h80, 32'h0, 32'h4000};
    // ctrl, awg sample, offset, gain, expected output
    logic [79:0] tab [10] = '{
        80'h0005_1000_0000_4000_1000,
        80'h0005_1000_0100_8000_2200,
        80'h0005_7000_2000_4000_7FFF,
        80'h0005_6000_0000_8000_7FFF,
        80'h0005_1000_0000_2000_0800,
        80'h0005_1000_0000_FFFF_2000,
        80'h0007_1000_0000_4000_F000,
        80'h0005_9000_E000_4000_8000,
        80'h0005_1000_0000_0000_0000,
        80'h0004_1000_0000_4000_0000};
    peoc_top #(.DEPTH(64), .SEQ_LEN(16)) u_peoc_top (
        .CORE_CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel),
        .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .DAC_DATA_O(dac), .PULSE_O(pulse));
    peoc_digitizer u_peoc_digitizer (.clk_i(clk), .rst_n_i(rst_n),
        .clr_i(clr), .pulse_i(pulse), .sample_i(dac), .hits_o(hits),
        .peak_o(peak));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        rd_q <= prdata;
        err_q <= pslverr;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            final_report();
        end
    end
    task automatic final_report();
        $display("checked %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic cmp(input string n, input logic [31:0] x,
                       input logic [31:0] g);
        samples_checked++;
        if (g !== x) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic rng(input string n, input logic [31:0] lo,
                       input logic [31:0] hi, input logic [31:0] g);
        samples_checked++;
        if ((g >= lo && g <= hi) !== 1'b1) begin
            errors++;
            $display("mismatch %s expected %0d..%0d seen %0d", n, lo, hi, g);
        end
    endtask
    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        pen <= 1'b0;
        #1;
        q = rd_q;
        e = err_q;
    endtask
    task automatic run(input logic [15:0] c, input logic [31:0] r,
                       input int n);
        apb(1'b1, `PEOC_OFF_RATE, r);
        apb(1'b1, `PEOC_OFF_CTRL, {16'h0, c});
        apb(1'b1, `PEOC_OFF_COUNT, 32'h0);
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        repeat (n) @(posedge clk);
        apb(1'b0, `PEOC_OFF_COUNT, 32'h0);
    endtask
    // Whole memory is cleared first: it holds garbage after reset
    task automatic spec(input logic [7:0] b1, input logic [7:0] b2);
        apb(1'b1, `PEOC_OFF_SPADDR, 32'h0);
        for (int j = 0; j < 64; j++)
            apb(1'b1, `PEOC_OFF_SPDATA, 32'h0);
        apb(1'b1, `PEOC_OFF_SPADDR, {24'h0, b1});
        apb(1'b1, `PEOC_OFF_SPDATA, 32'hFFFF);
        apb(1'b1, `PEOC_OFF_SPADDR, {24'h0, b2});
        apb(1'b1, `PEOC_OFF_SPDATA, 32'hFFFF);
    endtask
    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        pen = 1'b0;
        pwr = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        clr = 1'b0;
        cyc = 0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0);
            cmp("reset value", rv[i], q);
        end
        apb(1'b1, 8'h34, 32'hFFFF_FFFF);
        cmp("write refused", 32'h1, {31'h0, e});
        apb(1'b0, 8'h34, 32'h0);
        cmp("unmapped read", 32'h0, q);
        $display("test registers done");
        for (int i = 0; i < 10; i++) begin
            apb(1'b1, `PEOC_OFF_AWG, {16'h0, tab[i][63:48]});
            apb(1'b1, `PEOC_OFF_OFFSET, {16'h0, tab[i][47:32]});
            apb(1'b1, `PEOC_OFF_GAIN, {16'h0, tab[i][31:16]});
            apb(1'b1, `PEOC_OFF_CTRL, {16'h0, tab[i][79:64]});
            repeat (4) @(negedge clk);
            cmp("output", {16'h0, tab[i][15:0]}, {16'h0, dac});
        end
        apb(1'b1, `PEOC_OFF_GAIN, 32'hFFFF);
        apb(1'b0, `PEOC_OFF_GAIN, 32'h0);
        cmp("gain ceiling", 32'h8000, q);
        apb(1'b1, `PEOC_OFF_GAIN, 32'h4000);
        $display("test conditioning done");
        apb(1'b1, `PEOC_OFF_SHAPE, 32'h40);
        run(16'h0001, FAST, 800);
        rng("constant count", 97, 104, q);
        rng("constant hits", 97, 104, hits);
        run(16'h0021, FAST, 1600);
        rng("poisson count", 140, 260, q);
        run(16'h0000, FAST, 400);
        cmp("disabled count", 32'h0, q);
        $display("test timing done");
        spec(8'd17, 8'd32);
        apb(1'b1, `PEOC_OFF_SPADDR, 32'd17);
        apb(1'b0, `PEOC_OFF_SPDATA, 32'h0);
        cmp("bin readback", 32'hFFFF, q);
        run(16'h0001, SLOW, 1024);
        rng("fixed peak", 32'h400, 32'h800, {16'h0, peak});
        run(16'h0409, FAST, 800);
        rng("first count", 1, 110, q);
        run(16'h0489, FAST, 800);
        cmp("slice count", 32'h0, q);
        spec(8'd17, 8'd17);
        run(16'h0409, FAST, 800);
        cmp("first miss", 32'h0, q);
        run(16'h0449, FAST, 800);
        rng("max count", 1, 110, q);
        $display("test spectrum done");
        apb(1'b1, `PEOC_OFF_SEQ, 32'h0000_0200);
        apb(1'b1, `PEOC_OFF_SEQ, 32'h0001_0400);
        run(16'h1011, FAST, 800);
        rng("sequence count", 97, 104, q);
        rng("sequence peak", 32'h3C0, 32'h480, {16'h0, peak});
        $display("test sequence done");
        final_report();
    end
endmodule
`default_nettype wire
